/* pkg/elr_pkg.sv */
package elr_pkg;

	localparam int NUM_CH = 8;
	localparam int REG_W = 8;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 6;
	localparam int IDX_W = 5;

	// Register indices; byte address is four times the index
	localparam logic [4:0] IDX_GLOBAL_CONFIG = 5'h0f;
	localparam logic [4:0] IDX_TX_DRIVER_TRISTATE = 5'h12;
	localparam logic [4:0] IDX_ALARM_STATUS = 5'h13;
	localparam logic [4:0] IDX_ALARM_IRQ_MASK = 5'h14;
	localparam logic [4:0] IDX_ALARM_IRQ_FLAGS = 5'h15;
	localparam logic [4:0] IDX_BANK_POINTER = 5'h1f;
	localparam logic [4:0] IDX_EXP_FORCE_SINGLE_RAIL = 5'h00;
	localparam logic [4:0] IDX_EXP_CHANNEL_LINE_CODE = 5'h01;
	localparam logic [4:0] IDX_EXP_CLOCK_RECOVERY_DISABLE = 5'h02;
	localparam logic [4:0] IDX_EXP_RECEIVER_POWERDOWN = 5'h03;
	localparam logic [4:0] IDX_EXP_TRANSMITTER_POWERDOWN = 5'h04;
	localparam logic [4:0] IDX_EXP_EXCESS_ZERO_DETECT = 5'h05;
	localparam logic [4:0] IDX_EXP_VIOLATION_DETECT_OFF = 5'h06;
	localparam logic [4:0] IDX_EXP_RX_EQUALIZER_ENABLE = 5'h07;
	localparam logic [4:0] IDX_EXP_LAST_CONFIG = 5'h07;
	localparam logic [4:0] IDX_EXP_TEST_FIRST = 5'h08;
	localparam logic [4:0] IDX_EXP_TEST_LAST = 5'h1e;
	localparam int NUM_EXP = 8;

	// Global configuration field positions
	localparam int GC_ALARM_INSERT_ON_LOSS = 6;
	localparam int GC_PROTECTION_DISABLE = 5;
	localparam int GC_LINE_CODE_AMI = 4;
	localparam int GC_JITTER_BUFFER_DEPTH = 3;
	localparam int GC_JITTER_BANDWIDTH = 2;
	localparam int GC_JITTER_PLACEMENT_HI = 1;
	localparam int GC_JITTER_PLACEMENT_LO = 0;
	localparam logic [7:0] GC_WRITABLE_MASK = 8'h7f;

	localparam logic [1:0] JITTER_IN_TX = 2'h1;
	localparam logic [1:0] JITTER_IN_RX = 2'h3;

	localparam logic [7:0] BANK_PRIMARY = 8'h00;
	localparam logic [7:0] BANK_EXPANDED = 8'haa;

	localparam logic [7:0] RST_GLOBAL_CONFIG = 8'h00;
	localparam logic [7:0] RST_TX_DRIVER_TRISTATE = 8'h00;
	localparam logic [7:0] RST_ALARM_STATUS = 8'h00;
	localparam logic [7:0] RST_ALARM_IRQ_MASK = 8'h00;
	localparam logic [7:0] RST_ALARM_IRQ_FLAGS = 8'h00;
	localparam logic [7:0] RST_BANK_POINTER = BANK_PRIMARY;
	localparam logic [7:0] RST_EXP = 8'h00;

endpackage

/* design/elr_config_alarm_regs.sv */
`timescale 1ns/100ps
module elr_config_alarm_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [elr_pkg::ADDR_W-1:0] paddr,
	input wire logic [elr_pkg::DATA_W-1:0] pwdata,
	output logic [elr_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [elr_pkg::NUM_CH-1:0] alarm_indication_in,
	input wire logic [elr_pkg::NUM_CH-1:0] signal_absent_in,
	input wire logic [elr_pkg::NUM_CH-1:0] tx_negative_data_pin,
	input wire logic [elr_pkg::NUM_CH-1:0] tx_clock_pin,
	output logic [elr_pkg::NUM_CH-1:0] alarm_insert,
	output logic short_protect_enable,
	output logic jitter_depth_64,
	output logic jitter_bandwidth_high,
	output logic jitter_in_tx,
	output logic jitter_in_rx,
	output logic [elr_pkg::NUM_CH-1:0] tx_driver_hiz,
	output logic [elr_pkg::NUM_CH-1:0] tx_powered_down,
	output logic [elr_pkg::NUM_CH-1:0] single_rail,
	output logic [elr_pkg::NUM_CH-1:0] ami_select,
	output logic [elr_pkg::NUM_CH-1:0] clock_recovery_on,
	output logic [elr_pkg::NUM_CH-1:0] rx_powered_down,
	output logic [elr_pkg::NUM_CH-1:0] excess_zero_detect_on,
	output logic [elr_pkg::NUM_CH-1:0] violation_detect_on,
	output logic [elr_pkg::NUM_CH-1:0] rx_equalizer_on
);

	typedef struct packed {
		logic [7:0] global_config;
		logic [7:0] tx_driver_tristate;
		logic [7:0] alarm_indication;
		logic [7:0] alarm_indication_irq_mask;
		logic [7:0] alarm_indication_irq_flags;
		logic [7:0] bank_pointer;
		logic [elr_pkg::NUM_EXP-1:0][7:0] exp;
		logic [elr_pkg::DATA_W-1:0] prdata;
		logic pslverr;
		logic [7:0] alarm_insert;
		logic short_protect_enable;
		logic jitter_depth_64;
		logic jitter_bandwidth_high;
		logic jitter_in_tx;
		logic jitter_in_rx;
		logic [7:0] tx_driver_hiz;
		logic [7:0] tx_powered_down;
		logic [7:0] single_rail;
		logic [7:0] ami_select;
		logic [7:0] clock_recovery_on;
		logic [7:0] rx_powered_down;
		logic [7:0] excess_zero_detect_on;
		logic [7:0] violation_detect_on;
		logic [7:0] rx_equalizer_on;
	} elr_state_t;

	typedef enum {
		ELR_HIT_NONE,
		ELR_HIT_REG,
		ELR_HIT_TEST
	} elr_hit_t;

	elr_state_t s_r;
	elr_state_t s_nxt;

	// Register index of a byte address; the two low bits select no byte
	function automatic logic [elr_pkg::IDX_W-1:0] reg_index(
		input logic [elr_pkg::ADDR_W-1:0] addr);
		return addr[elr_pkg::IDX_MSB:elr_pkg::IDX_LSB];
	endfunction

	// Jitter placement field of a global configuration value
	function automatic logic [1:0] jitter_field(input logic [7:0] gc);
		return gc[elr_pkg::GC_JITTER_PLACEMENT_HI:elr_pkg::GC_JITTER_PLACEMENT_LO];
	endfunction

	// Classifies an address in the bank that is currently selected
	function automatic elr_hit_t decode_hit(input logic [elr_pkg::ADDR_W-1:0] addr,
		input logic expanded);
		logic [elr_pkg::IDX_W-1:0] idx;
		elr_hit_t hit;
		idx = reg_index(addr);
		hit = ELR_HIT_NONE;
		if (addr[elr_pkg::ADDR_W-1] == 1'b0) begin
			if (idx == elr_pkg::IDX_BANK_POINTER) begin
				hit = ELR_HIT_REG;
			end else if (expanded) begin
				if (idx <= elr_pkg::IDX_EXP_LAST_CONFIG) begin
					hit = ELR_HIT_REG;
				end else if (idx >= elr_pkg::IDX_EXP_TEST_FIRST &&
					idx <= elr_pkg::IDX_EXP_TEST_LAST) begin
					hit = ELR_HIT_TEST;
				end
			end else begin
				case (idx)
					elr_pkg::IDX_GLOBAL_CONFIG,
					elr_pkg::IDX_TX_DRIVER_TRISTATE,
					elr_pkg::IDX_ALARM_STATUS,
					elr_pkg::IDX_ALARM_IRQ_MASK,
					elr_pkg::IDX_ALARM_IRQ_FLAGS: begin
						hit = ELR_HIT_REG;
					end
					default: begin
						hit = ELR_HIT_NONE;
					end
				endcase
			end
		end
		return hit;
	endfunction

	// Read value of the selected register, zero where nothing is stored
	function automatic logic [7:0] read_value(input elr_state_t st,
		input logic [elr_pkg::ADDR_W-1:0] addr, input logic expanded);
		logic [elr_pkg::IDX_W-1:0] idx;
		logic [7:0] val;
		idx = reg_index(addr);
		val = 8'h00;
		if (idx == elr_pkg::IDX_BANK_POINTER) begin
			val = st.bank_pointer;
		end else if (expanded) begin
			if (idx <= elr_pkg::IDX_EXP_LAST_CONFIG) begin
				val = st.exp[idx[2:0]];
			end
		end else begin
			case (idx)
				elr_pkg::IDX_GLOBAL_CONFIG: begin
					val = st.global_config;
				end
				elr_pkg::IDX_TX_DRIVER_TRISTATE: begin
					val = st.tx_driver_tristate;
				end
				elr_pkg::IDX_ALARM_STATUS: begin
					val = st.alarm_indication;
				end
				elr_pkg::IDX_ALARM_IRQ_MASK: begin
					val = st.alarm_indication_irq_mask;
				end
				elr_pkg::IDX_ALARM_IRQ_FLAGS: begin
					val = st.alarm_indication_irq_flags;
				end
				default: begin
					val = 8'h00;
				end
			endcase
		end
		return val;
	endfunction

	logic expanded;
	logic setup_phase;
	logic access_phase;
	elr_hit_t hit;
	logic [elr_pkg::IDX_W-1:0] idx;
	logic [7:0] wbyte;
	logic status_read;
	logic [7:0] alarm_change;
	logic [7:0] forced;
	logic [7:0] ch_single;
	logic [7:0] ch_ami;

	assign expanded = (s_r.bank_pointer == elr_pkg::BANK_EXPANDED);
	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;
	assign hit = decode_hit(paddr, expanded);
	assign idx = reg_index(paddr);
	assign wbyte = pwdata[7:0];

	always_comb begin
		s_nxt = s_r;

		// Read data and error prepared in setup so the access needs no wait
		if (setup_phase) begin
			if (hit == ELR_HIT_NONE) begin
				// Upper address half is refused, not aliased; a refused read shows zero
				s_nxt.prdata = 32'h00000000;
			end else begin
				s_nxt.prdata = {24'h000000, read_value(s_r, paddr, expanded)};
			end
			s_nxt.pslverr = (hit == ELR_HIT_NONE);
		end

		// Writes land only at the completing access edge
		if (access_phase && pwrite && hit == ELR_HIT_REG) begin
			if (idx == elr_pkg::IDX_BANK_POINTER) begin
				s_nxt.bank_pointer = wbyte;
			end else if (expanded) begin
				// Only words 00-07 decode as registers here; test words never land
				s_nxt.exp[idx[2:0]] = wbyte;
			end else begin
				case (idx)
					elr_pkg::IDX_GLOBAL_CONFIG: begin
						s_nxt.global_config = wbyte & elr_pkg::GC_WRITABLE_MASK;
					end
					elr_pkg::IDX_TX_DRIVER_TRISTATE: begin
						s_nxt.tx_driver_tristate = wbyte;
					end
					elr_pkg::IDX_ALARM_IRQ_MASK: begin
						s_nxt.alarm_indication_irq_mask = wbyte;
					end
					elr_pkg::IDX_ALARM_STATUS,
					elr_pkg::IDX_ALARM_IRQ_FLAGS: begin
						// Read-only words: the write is dropped without an error
						s_nxt.global_config = s_r.global_config;
					end
					default: begin
						s_nxt.global_config = s_r.global_config;
					end
				endcase
			end
		end

		// Status tracks the detector; a change under mask latches a flag
		s_nxt.alarm_indication = alarm_indication_in;
		alarm_change = alarm_indication_in ^ s_r.alarm_indication;
		status_read = access_phase && !pwrite && !expanded && hit == ELR_HIT_REG &&
			idx == elr_pkg::IDX_ALARM_STATUS;
		// Set beats clear so an edge during the read is not lost
		s_nxt.alarm_indication_irq_flags =
			(s_r.alarm_indication_irq_flags & ~{8{status_read}}) |
			(alarm_change & s_r.alarm_indication_irq_mask);

		// Registered control outputs
		s_nxt.alarm_insert = signal_absent_in &
			{8{s_r.global_config[elr_pkg::GC_ALARM_INSERT_ON_LOSS]}};
		s_nxt.short_protect_enable =
			!s_r.global_config[elr_pkg::GC_PROTECTION_DISABLE];
		s_nxt.jitter_depth_64 = s_r.global_config[elr_pkg::GC_JITTER_BUFFER_DEPTH];
		s_nxt.jitter_bandwidth_high =
			s_r.global_config[elr_pkg::GC_JITTER_BANDWIDTH];
		s_nxt.jitter_in_tx = (jitter_field(s_r.global_config) == elr_pkg::JITTER_IN_TX);
		s_nxt.jitter_in_rx = (jitter_field(s_r.global_config) == elr_pkg::JITTER_IN_RX);

		s_nxt.tx_powered_down = s_r.exp[elr_pkg::IDX_EXP_TRANSMITTER_POWERDOWN[2:0]] |
			~tx_clock_pin;
		// A powered-down transmitter floats its driver as well
		s_nxt.tx_driver_hiz = s_r.tx_driver_tristate | s_nxt.tx_powered_down;

		s_nxt.clock_recovery_on =
			~s_r.exp[elr_pkg::IDX_EXP_CLOCK_RECOVERY_DISABLE[2:0]];
		// Forcing single rail is only honoured with recovery running
		forced = s_r.exp[elr_pkg::IDX_EXP_FORCE_SINGLE_RAIL[2:0]] &
			s_nxt.clock_recovery_on;
		ch_single = forced | (~forced & tx_negative_data_pin);
		s_nxt.single_rail = ch_single;
		ch_ami = (forced & s_r.exp[elr_pkg::IDX_EXP_CHANNEL_LINE_CODE[2:0]]) |
			(~forced & {8{s_r.global_config[elr_pkg::GC_LINE_CODE_AMI]}});
		s_nxt.ami_select = ch_ami;

		s_nxt.rx_powered_down = s_r.exp[elr_pkg::IDX_EXP_RECEIVER_POWERDOWN[2:0]];
		// Decoder checks only mean something for single-rail HDB3
		s_nxt.excess_zero_detect_on = s_r.exp[elr_pkg::IDX_EXP_EXCESS_ZERO_DETECT[2:0]] &
			ch_single & ~ch_ami;
		s_nxt.violation_detect_on = ~s_r.exp[elr_pkg::IDX_EXP_VIOLATION_DETECT_OFF[2:0]] &
			ch_single & ~ch_ami;
		s_nxt.rx_equalizer_on = s_r.exp[elr_pkg::IDX_EXP_RX_EQUALIZER_ENABLE[2:0]];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r.global_config <= elr_pkg::RST_GLOBAL_CONFIG;
			s_r.tx_driver_tristate <= elr_pkg::RST_TX_DRIVER_TRISTATE;
			s_r.alarm_indication <= elr_pkg::RST_ALARM_STATUS;
			s_r.alarm_indication_irq_mask <= elr_pkg::RST_ALARM_IRQ_MASK;
			s_r.alarm_indication_irq_flags <= elr_pkg::RST_ALARM_IRQ_FLAGS;
			s_r.bank_pointer <= elr_pkg::RST_BANK_POINTER;
			s_r.exp <= {elr_pkg::NUM_EXP{elr_pkg::RST_EXP}};
			s_r.prdata <= 32'h00000000;
			s_r.pslverr <= 1'b0;
			s_r.alarm_insert <= 8'h00;
			s_r.short_protect_enable <= 1'b1;
			s_r.jitter_depth_64 <= 1'b0;
			s_r.jitter_bandwidth_high <= 1'b0;
			s_r.jitter_in_tx <= 1'b0;
			s_r.jitter_in_rx <= 1'b0;
			s_r.tx_driver_hiz <= 8'h00;
			s_r.tx_powered_down <= 8'h00;
			s_r.single_rail <= 8'h00;
			s_r.ami_select <= 8'h00;
			s_r.clock_recovery_on <= 8'hff;
			s_r.rx_powered_down <= 8'h00;
			s_r.excess_zero_detect_on <= 8'h00;
			s_r.violation_detect_on <= 8'h00;
			s_r.rx_equalizer_on <= 8'h00;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign prdata = s_r.prdata;
	assign pslverr = s_r.pslverr;
	assign alarm_insert = s_r.alarm_insert;
	assign short_protect_enable = s_r.short_protect_enable;
	assign jitter_depth_64 = s_r.jitter_depth_64;
	assign jitter_bandwidth_high = s_r.jitter_bandwidth_high;
	assign jitter_in_tx = s_r.jitter_in_tx;
	assign jitter_in_rx = s_r.jitter_in_rx;
	assign tx_driver_hiz = s_r.tx_driver_hiz;
	assign tx_powered_down = s_r.tx_powered_down;
	assign single_rail = s_r.single_rail;
	assign ami_select = s_r.ami_select;
	assign clock_recovery_on = s_r.clock_recovery_on;
	assign rx_powered_down = s_r.rx_powered_down;
	assign excess_zero_detect_on = s_r.excess_zero_detect_on;
	assign violation_detect_on = s_r.violation_detect_on;
	assign rx_equalizer_on = s_r.rx_equalizer_on;

endmodule

/* dv/elr_checker.sv */
`timescale 1ns/100ps
module elr_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [7:0] signal_absent_in,
	input wire logic [7:0] tx_negative_data_pin,
	input wire logic [7:0] tx_clock_pin,
	input wire logic [7:0] alarm_insert,
	input wire logic short_protect_enable,
	input wire logic jitter_in_tx,
	input wire logic jitter_in_rx,
	input wire logic [7:0] tx_driver_hiz,
	input wire logic [7:0] tx_powered_down,
	input wire logic [7:0] single_rail
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic exp_r;
	logic wr;
	assign wr = psel && penable && pwrite && !exp_r;
	// Index 0f and 12 are test registers in the expanded bank
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) exp_r <= 1'b0;
		else if (psel && penable && pwrite && paddr == 8'h7c) exp_r <= pwdata[7:0] == 8'haa;
	a_gc_protect: assert property (
		wr && paddr == 8'h3c |-> ##2 short_protect_enable == !$past(pwdata[5], 2))
		else $error("protection enable wrong");
	a_gc_placement: assert property (
		wr && paddr == 8'h3c |-> ##2 jitter_in_tx == ($past(pwdata[1:0], 2) == 2'h1)
		&& jitter_in_rx == ($past(pwdata[1:0], 2) == 2'h3)) else $error("placement wrong");
	a_tristate_wr: assert property (
		wr && paddr == 8'h48 |-> ##2 (tx_driver_hiz & $past(pwdata[7:0], 2))
		== $past(pwdata[7:0], 2)) else $error("driver not high impedance");
	a_insert_on_loss: assert property (
		$past(presetn) |-> (alarm_insert & ~$past(signal_absent_in)) == 8'h00)
		else $error("alarm insert without loss");
	a_clock_pin_off: assert property (
		$past(presetn) |-> (~$past(tx_clock_pin) & ~tx_powered_down) == 8'h00)
		else $error("low clock pin not powered down");
	a_pin_rail: assert property (
		$past(presetn) |-> (~$past(tx_negative_data_pin) | single_rail) == 8'hff)
		else $error("rail pin ignored");
	a_hiz_pdown: assert property (
		(tx_powered_down & ~tx_driver_hiz) == 8'h00) else $error("powered down driver active");
	a_unmapped_err: assert property (
		psel && !penable && paddr[7] |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_bank_ok: assert property (
		psel && !penable && paddr == 8'h7c |=> !pslverr) else $error("bank pointer refused");
endmodule

/* dv/elr_apb_host.sv */
`timescale 1ns/100ps
module elr_apb_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// Caller enters just after an edge; request held until pready edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

/* dv/elr_config_alarm_regs_tb_top.sv */
`timescale 1ns/100ps
module elr_config_alarm_regs_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, short_protect_enable;
	logic jitter_depth_64, jitter_bandwidth_high, jitter_in_tx, jitter_in_rx;
	logic [7:0] paddr, alarm_indication_in, signal_absent_in, tx_negative_data_pin;
	logic [7:0] tx_clock_pin, alarm_insert, tx_driver_hiz, tx_powered_down, single_rail;
	logic [7:0] ami_select, clock_recovery_on, rx_powered_down, excess_zero_detect_on;
	logic [7:0] violation_detect_on, rx_equalizer_on;
	logic [31:0] pwdata, prdata, rd;
	int fail_count = 0;
	int checked = 0;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e;} elr_row_t;
	elr_row_t rows[18] = '{
		'{8'h3c, 8'h80, 8'h00, 1'b0},
		'{8'h48, 8'h0f, 8'h0f, 1'b0},
		'{8'h4c, 8'hff, 8'h00, 1'b0},
		'{8'h54, 8'hff, 8'h00, 1'b0},
		'{8'h40, 8'h11, 8'h00, 1'b1},
		'{8'h80, 8'h11, 8'h00, 1'b1},
		'{8'hc8, 8'h55, 8'h00, 1'b1},
		'{8'h7c, 8'haa, 8'haa, 1'b0},
		'{8'h00, 8'h03, 8'h03, 1'b0},
		'{8'h04, 8'h01, 8'h01, 1'b0},
		'{8'h08, 8'h02, 8'h02, 1'b0},
		'{8'h0c, 8'h44, 8'h44, 1'b0},
		'{8'h10, 8'h02, 8'h02, 1'b0},
		'{8'h14, 8'hff, 8'hff, 1'b0},
		'{8'h18, 8'h00, 8'h00, 1'b0},
		'{8'h1c, 8'h21, 8'h21, 1'b0},
		'{8'h20, 8'h00, 8'h00, 1'b0},
		'{8'h7c, 8'h00, 8'h00, 1'b0}};
	elr_config_alarm_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .alarm_indication_in(alarm_indication_in),
		.signal_absent_in(signal_absent_in), .tx_negative_data_pin(tx_negative_data_pin),
		.tx_clock_pin(tx_clock_pin), .alarm_insert(alarm_insert),
		.short_protect_enable(short_protect_enable), .jitter_depth_64(jitter_depth_64),
		.jitter_bandwidth_high(jitter_bandwidth_high), .jitter_in_tx(jitter_in_tx),
		.jitter_in_rx(jitter_in_rx), .tx_driver_hiz(tx_driver_hiz),
		.tx_powered_down(tx_powered_down), .single_rail(single_rail), .ami_select(ami_select),
		.clock_recovery_on(clock_recovery_on), .rx_powered_down(rx_powered_down),
		.excess_zero_detect_on(excess_zero_detect_on), .violation_detect_on(violation_detect_on),
		.rx_equalizer_on(rx_equalizer_on));
	elr_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		host.xfer(1'b1, a, {24'h0, d}, rd, er);
	endtask
	task automatic rdx(input logic [7:0] a, input logic [7:0] x);
		@(posedge pclk);
		host.xfer(1'b0, a, 32'h0, rd, er);
		chk("rdata", rd, {24'h0, x});
	endtask
	task automatic finish_test;
		if (fail_count == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		finish_test;
	end
	initial begin
		presetn = 1'b0;
		alarm_indication_in = 8'h00;
		signal_absent_in = 8'h00;
		tx_negative_data_pin = 8'h80;
		tx_clock_pin = 8'hff;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		chk("prot", short_protect_enable, 1'b1);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rdx(rows[i].a, rows[i].q);
			chk("err", er, rows[i].e);
		end
		chk("hiz", tx_driver_hiz, 8'h0f);
		chk("tpd", tx_powered_down, 8'h02);
		chk("rail", single_rail, 8'h81);
		chk("ami", ami_select, 8'h01);
		chk("crec", clock_recovery_on, 8'hfd);
		chk("rpd", rx_powered_down, 8'h44);
		chk("ezd", excess_zero_detect_on, 8'h80);
		chk("cvd", violation_detect_on, 8'h80);
		chk("eq", rx_equalizer_on, 8'h21);
		@(posedge pclk) signal_absent_in <= 8'h81;
		for (int j = 0; j < 4; j++) begin
			wr(8'h3c, {1'b0, j[1], j[0], j[1], j[0], j[1], j[1:0]});
			repeat (3) @(posedge pclk);
			chk("ins", alarm_insert, {8{j[1]}} & 8'h81);
			chk("prot", short_protect_enable, !j[0]);
			chk("ami", ami_select, {8{j[1]}} | 8'h01);
			chk("dep", jitter_depth_64, j[0]);
			chk("bw", jitter_bandwidth_high, j[1]);
			chk("jtx", jitter_in_tx, j == 1);
			chk("jrx", jitter_in_rx, j == 3);
		end
		wr(8'h50, 8'h0f);
		@(posedge pclk) alarm_indication_in <= 8'h11;
		repeat (3) @(posedge pclk);
		rdx(8'h54, 8'h01);
		rdx(8'h4c, 8'h11);
		rdx(8'h54, 8'h00);
		@(posedge pclk) alarm_indication_in <= 8'h10;
		repeat (3) @(posedge pclk);
		rdx(8'h54, 8'h01);
		@(posedge pclk) tx_clock_pin <= 8'hef;
		repeat (3) @(posedge pclk);
		chk("tpd", tx_powered_down, 8'h12);
		chk("hiz", tx_driver_hiz, 8'h1f);
		@(posedge pclk) presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		chk("crec", clock_recovery_on, 8'hff);
		rdx(8'h7c, 8'h00);
		rdx(8'h3c, 8'h00);
		finish_test;
	end
endmodule
bind elr_config_alarm_regs elr_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pslverr(pslverr), .signal_absent_in(signal_absent_in),
	.tx_negative_data_pin(tx_negative_data_pin), .tx_clock_pin(tx_clock_pin),
	.alarm_insert(alarm_insert), .short_protect_enable(short_protect_enable),
	.jitter_in_tx(jitter_in_tx), .jitter_in_rx(jitter_in_rx), .tx_driver_hiz(tx_driver_hiz),
	.tx_powered_down(tx_powered_down), .single_rail(single_rail));
